// [rtl/adc_compare_delay_result.sv]
// result holding, threshold compare, fault brake and trigger delay beside a 12-bit converter
// assumes converter handshake and adcTick come from logic on clk; trigger and pins are asynchronous
//
// Notes on behaviour
// - brake asserted when enabled and compare high
// - brake clears pwm run bit by pulse
// - polarity picks >= or < threshold
// - comparator works only while enabled
// - compare output read-only, refreshed per conversion
// - delay is nine bits across two registers
// - wait programmed converter clocks before starting
// - delay applies to external triggers only
// - disconnect bit forces digital pin read zero
// - result split high byte, low nibble, read-only
// - threshold split high byte, low nibble, writable
// - second control register resets to zero
// - done flag blocks new conversions until cleared
// - triggers ignored while converter busy
`timescale 1ns/1ps
module adc_compare_delay_result
    import adc_cmp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire apb_req_t apbReq,
    output apb_rsp_t apbRsp,
    // converter side
    input wire logic adcTick,
    input wire logic extTrigPin,
    output logic convStart,
    input wire logic convDone,
    input wire logic [11:0] convData,
    // pwm fault brake
    output logic faultBrake,
    output logic pwmRunClear,
    // analog pin digital path
    input wire logic [7:0] pinRaw,
    output logic [7:0] pinDigital,
    // interrupt
    output logic irq
);
    logic [7:0] resultHigh;
    logic [3:0] resultLow;
    logic [7:0] compareHigh;
    logic [3:0] compareLow;
    logic brakeEn;
    logic polarity;
    logic cmpEn;
    logic cmpOut;
    logic delay8;
    logic [7:0] delayLow;
    logic [7:0] disconnect;
    logic extEnable;
    logic doneFlag;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqEnable;
    conv_state_t state;
    conv_state_t next_state;
    logic [8:0] delayCnt;
    logic trigMeta;
    logic trigSync;
    logic trigPrev;
    logic [7:0] pinMeta;
    logic [7:0] pinSync;
    logic [31:0] prdata;
    logic pslverr;

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        logic [8:0] i;
        i = a[ADDR_W-1:2];
        isMapped = (a[1:0] == 2'b00) && (i inside {IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_COMPARE_LOW,
            IDX_COMPARE_HIGH, IDX_CTRL2, IDX_DELAY_LOW, IDX_DISCONNECT, IDX_RUN, IDX_IRQ_STATUS,
            IDX_IRQ_CLEAR, IDX_IRQ_ENABLE});
    endfunction

    function automatic logic wrHit(input apb_req_t r, input logic [8:0] target);
        wrHit = r.psel && r.penable && r.pwrite && r.paddr[1:0] == 2'b00 && r.paddr[ADDR_W-1:2] == target;
    endfunction

    wire logic setupPhase = apbReq.psel && !apbReq.penable;
    wire logic [8:0] idx = apbReq.paddr[ADDR_W-1:2];
    wire logic [8:0] delayValue = {delay8, delayLow};
    wire logic [11:0] threshold = {compareHigh, compareLow};
    wire logic swStart = wrHit(apbReq, IDX_RUN) && apbReq.pwdata[RUN_START];
    wire logic extEdge = trigSync && !trigPrev;
    wire logic canStart = state == ST_IDLE && !doneFlag;
    wire logic finish = state == ST_CONV && convDone;
    wire logic [IRQ_W-1:0] irqClear = wrHit(apbReq, IDX_IRQ_CLEAR) ? apbReq.pwdata[IRQ_W-1:0] : '0;
    wire logic brakeCond = brakeEn && cmpOut;
    logic next_cmpOut;
    logic goConv;

    // one-cycle answer: pready is never held low
    always_comb begin
        apbRsp.pready = 1'b1;
        apbRsp.prdata = prdata;
        apbRsp.pslverr = pslverr;
    end

    // asynchronous trigger and pins pass two flops before any use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trigMeta <= 1'b0;
            trigSync <= 1'b0;
            trigPrev <= 1'b0;
            pinMeta <= REG_RESET;
            pinSync <= REG_RESET;
        end else begin
            trigMeta <= extTrigPin;
            trigSync <= trigMeta;
            trigPrev <= trigSync;
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinDigital <= REG_RESET;
        end else begin
            pinDigital <= pinSync & ~disconnect;
        end
    end

    // conversion sequencer
    always_comb begin
        next_state = state;
        goConv = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (canStart && swStart) begin
                    next_state = ST_CONV;
                    goConv = 1'b1;
                end else if (canStart && extEnable && extEdge) begin
                    if (delayValue == '0) begin
                        next_state = ST_CONV;
                        goConv = 1'b1;
                    end else begin
                        next_state = ST_DELAY;
                    end
                end
            end
            ST_DELAY: begin
                if (adcTick && delayCnt == DELAY_ONE) begin
                    next_state = ST_CONV;
                    goConv = 1'b1;
                end
            end
            ST_CONV: begin
                if (convDone) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // triggers seen in delay or conversion fall through the case above
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            convStart <= 1'b0;
        end else begin
            state <= next_state;
            convStart <= goConv;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            delayCnt <= '0;
        end else if (state == ST_IDLE) begin
            delayCnt <= delayValue;
        end else if (state == ST_DELAY && adcTick) begin
            delayCnt <= delayCnt - DELAY_ONE;
        end
    end

    // done flag: set beats a software clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            doneFlag <= 1'b0;
        end else if (finish) begin
            doneFlag <= 1'b1;
        end else if (wrHit(apbReq, IDX_RUN) && !apbReq.pwdata[RUN_DONE]) begin
            doneFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resultHigh <= REG_RESET;
            resultLow <= '0;
        end else if (finish) begin
            resultHigh <= convData[11:4];
            resultLow <= convData[3:0];
        end
    end

    always_comb begin
        next_cmpOut = cmpOut;
        if (!cmpEn) begin
            next_cmpOut = 1'b0;
        end else if (finish) begin
            next_cmpOut = polarity ? (convData < threshold) : (convData >= threshold);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmpOut <= 1'b0;
        end else begin
            cmpOut <= next_cmpOut;
        end
    end

    // run clear is a single pulse per brake onset so software can restart pwm
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultBrake <= 1'b0;
            pwmRunClear <= 1'b0;
        end else begin
            faultBrake <= brakeCond;
            pwmRunClear <= brakeCond && !faultBrake;
        end
    end

    // software writable registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            brakeEn <= 1'b0;
            polarity <= 1'b0;
            cmpEn <= 1'b0;
            delay8 <= 1'b0;
            compareHigh <= REG_RESET;
            compareLow <= '0;
            delayLow <= REG_RESET;
            disconnect <= REG_RESET;
            extEnable <= 1'b0;
            irqEnable <= '0;
        end else begin
            if (wrHit(apbReq, IDX_CTRL2)) begin
                brakeEn <= apbReq.pwdata[CTL2_BRAKE];
                polarity <= apbReq.pwdata[CTL2_POLARITY];
                cmpEn <= apbReq.pwdata[CTL2_CMP_EN];
                delay8 <= apbReq.pwdata[CTL2_DELAY8];
            end
            if (wrHit(apbReq, IDX_COMPARE_HIGH)) begin
                compareHigh <= apbReq.pwdata[7:0];
            end
            if (wrHit(apbReq, IDX_COMPARE_LOW)) begin
                compareLow <= apbReq.pwdata[3:0];
            end
            if (wrHit(apbReq, IDX_DELAY_LOW)) begin
                delayLow <= apbReq.pwdata[7:0];
            end
            if (wrHit(apbReq, IDX_DISCONNECT)) begin
                disconnect <= apbReq.pwdata[7:0];
            end
            if (wrHit(apbReq, IDX_RUN)) begin
                extEnable <= apbReq.pwdata[RUN_EXT];
            end
            if (wrHit(apbReq, IDX_IRQ_ENABLE)) begin
                irqEnable <= apbReq.pwdata[IRQ_W-1:0];
            end
        end
    end

    // sticky events; a new event outweighs a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatus <= '0;
        end else begin
            irqStatus <= (irqStatus & ~irqClear) | {brakeCond && !faultBrake, next_cmpOut && !cmpOut, finish};
        end
    end

    assign irq = |(irqStatus & irqEnable);

    // read data is prepared in the setup cycle, held through the access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= !isMapped(apbReq.paddr);
            prdata <= '0;
            if (apbReq.paddr[1:0] == 2'b00) begin
                unique case (idx)
                    IDX_RESULT_LOW: prdata <= {28'h0000000, resultLow};
                    IDX_RESULT_HIGH: prdata <= {24'h000000, resultHigh};
                    IDX_COMPARE_LOW: prdata <= {28'h0000000, compareLow};
                    IDX_COMPARE_HIGH: prdata <= {24'h000000, compareHigh};
                    IDX_CTRL2: prdata <= {24'h000000, brakeEn, polarity, cmpEn, cmpOut, 3'h0, delay8};
                    IDX_DELAY_LOW: prdata <= {24'h000000, delayLow};
                    IDX_DISCONNECT: prdata <= {24'h000000, disconnect};
                    IDX_RUN: prdata <= {24'h000000, doneFlag, 5'h00, extEnable, state != ST_IDLE};
                    IDX_IRQ_STATUS: prdata <= {29'h00000000, irqStatus};
                    IDX_IRQ_ENABLE: prdata <= {29'h00000000, irqEnable};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    property p_brake;
        @(posedge clk) disable iff (rst) brakeEn && cmpOut |=> faultBrake;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not asserted");

    property p_runclear;
        @(posedge clk) disable iff (rst) $rose(faultBrake) |-> pwmRunClear ##1 !pwmRunClear;
    endproperty
    a_runclear: assert property (p_runclear) else $error("run clear pulse wrong");

    property p_polarity;
        @(posedge clk) disable iff (rst) finish && cmpEn |=>
            cmpOut == ($past(polarity) ? ($past(convData) < $past(threshold)) : ($past(convData) >= $past(threshold)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("compare result wrong");

    property p_cmpoff;
        @(posedge clk) disable iff (rst) !cmpEn |=> !cmpOut;
    endproperty
    a_cmpoff: assert property (p_cmpoff) else $error("comparator active while off");

    property p_cmphold;
        @(posedge clk) disable iff (rst) !finish && cmpEn |=> $stable(cmpOut);
    endproperty
    a_cmphold: assert property (p_cmphold) else $error("compare changed without conversion");

    property p_delayend;
        @(posedge clk) disable iff (rst) state == ST_DELAY && adcTick && delayCnt == DELAY_ONE
            |=> convStart && state == ST_CONV;
    endproperty
    a_delayend: assert property (p_delayend) else $error("delayed start missing");

    property p_swnodelay;
        @(posedge clk) disable iff (rst) canStart && swStart |=> convStart && state == ST_CONV;
    endproperty
    a_swnodelay: assert property (p_swnodelay) else $error("software start delayed");

    property p_pinoff;
        @(posedge clk) disable iff (rst) 1'b1 |=> (pinDigital & $past(disconnect)) == 8'h00;
    endproperty
    a_pinoff: assert property (p_pinoff) else $error("disconnected pin reads high");

    property p_result;
        @(posedge clk) disable iff (rst) finish |=> {resultHigh, resultLow} == $past(convData) && doneFlag;
    endproperty
    a_result: assert property (p_result) else $error("result not captured");

    property p_doneblock;
        @(posedge clk) disable iff (rst) doneFlag |-> !convStart;
    endproperty
    a_doneblock: assert property (p_doneblock) else $error("start while done flag set");

    property p_busy;
        @(posedge clk) disable iff (rst) state == ST_CONV |=> !convStart;
    endproperty
    a_busy: assert property (p_busy) else $error("start while busy");

    property p_rundone;
        @(posedge clk) disable iff (rst) pwmRunClear |-> faultBrake;
    endproperty
    a_rundone: assert property (p_rundone) else $error("run clear without brake");

    // software writes must never reach the result registers
    property p_resulthold;
        @(posedge clk) disable iff (rst) !finish |=> $stable(resultHigh) && $stable(resultLow);
    endproperty
    a_resulthold: assert property (p_resulthold) else $error("result changed without conversion");

    property p_extdelay;
        @(posedge clk) disable iff (rst) canStart && !swStart && extEnable && extEdge && delayValue != '0
            |=> state == ST_DELAY && !convStart;
    endproperty
    a_extdelay: assert property (p_extdelay) else $error("external start not delayed");
endmodule

// [rtl/adc_cmp_pkg.sv]
// shared constants and types for the converter compare, brake and delay block
// assumes a 32-bit APB master and a single 125 MHz clock domain
package adc_cmp_pkg;
    localparam int ADDR_W = 11;
    // register indices; byte address is four times the index
    localparam logic [8:0] IDX_RESULT_LOW = 9'h0C2;
    localparam logic [8:0] IDX_RESULT_HIGH = 9'h0C3;
    localparam logic [8:0] IDX_COMPARE_LOW = 9'h0CE;
    localparam logic [8:0] IDX_COMPARE_HIGH = 9'h0CF;
    localparam logic [8:0] IDX_CTRL2 = 9'h0E2;
    localparam logic [8:0] IDX_DELAY_LOW = 9'h0E3;
    localparam logic [8:0] IDX_DISCONNECT = 9'h0F6;
    localparam logic [8:0] IDX_RUN = 9'h100;
    localparam logic [8:0] IDX_IRQ_STATUS = 9'h101;
    localparam logic [8:0] IDX_IRQ_CLEAR = 9'h102;
    localparam logic [8:0] IDX_IRQ_ENABLE = 9'h103;
    // second control register fields
    localparam int CTL2_BRAKE = 7;
    localparam int CTL2_POLARITY = 6;
    localparam int CTL2_CMP_EN = 5;
    localparam int CTL2_CMP_OUT = 4;
    localparam int CTL2_DELAY8 = 0;
    // run register fields
    localparam int RUN_START = 0;
    localparam int RUN_EXT = 1;
    localparam int RUN_DONE = 7;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CMP = 1;
    localparam int IRQ_BRAKE = 2;
    localparam int IRQ_W = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [8:0] DELAY_ONE = 9'h001;

    typedef enum {ST_IDLE, ST_DELAY, ST_CONV} conv_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic [ADDR_W-1:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;
endpackage

// [tb/adc_converter_model.sv]
// converter stand-in: converter clock ticks and a fixed-latency conversion
// assumes one clk domain; the bench sets the value returned on nextData
`timescale 1ns/1ps
module adc_converter_model
    import adc_cmp_pkg::*;
#(
    parameter int TICK_DIV = 8,
    parameter int CONV_CYCLES = 6
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // converter handshake
    input wire logic convStart,
    input wire logic [11:0] nextData,
    output logic adcTick,
    output logic convDone,
    output logic [11:0] convData
);
    int divCnt;
    int convCnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt <= 0;
            convCnt <= 0;
            adcTick <= 1'b0;
            convDone <= 1'b0;
            convData <= 12'hA5A;
        end else begin
            divCnt <= (divCnt == TICK_DIV - 1) ? 0 : divCnt + 1;
            adcTick <= (divCnt == TICK_DIV - 1);
            convDone <= 1'b0;
            // data is only good with convDone; toggling elsewhere exposes late sampling
            convData <= ~convData;
            if (convStart) begin
                convCnt <= CONV_CYCLES;
            end else if (convCnt > 0) begin
                convCnt <= convCnt - 1;
                if (convCnt == 1) begin
                    convDone <= 1'b1;
                    convData <= nextData;
                end
            end
        end
    end
endmodule

// [tb/adc_compare_delay_result_tb_top.sv]
// self-checking bench: registers, conversions, compare, brake, trigger delay, pin disconnect
// assumes the design package and the converter stand-in are compiled first
`timescale 1ns/1ps
module adc_compare_delay_result_tb_top
    import adc_cmp_pkg::*;
;
    logic clk;
    logic rst;
    apb_req_t apbReq;
    apb_rsp_t apbRsp;
    logic adcTick, extTrigPin, convStart, convDone, faultBrake, pwmRunClear, irq;
    logic [11:0] convData, nextData;
    logic [7:0] pinRaw, pinDigital;
    logic [31:0] rdData;
    logic lastErr;
    int errors, tests_run, starts, clears, ticks, lastTicks, t0, s0;
    logic [8:0] regIdx [7] = '{IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_COMPARE_LOW, IDX_COMPARE_HIGH,
        IDX_CTRL2, IDX_DELAY_LOW, IDX_DISCONNECT};
    logic [7:0] ctlTab [5] = '{8'h20, 8'h60, 8'h60, 8'h20, 8'h00};
    logic [11:0] datTab [5] = '{12'h803, 12'h803, 12'h802, 12'h802, 12'hFFF};
    logic [7:0] expTab [5] = '{8'h30, 8'h60, 8'h70, 8'h20, 8'h00};

    adc_compare_delay_result u_dut (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .adcTick(adcTick),
        .extTrigPin(extTrigPin), .convStart(convStart), .convDone(convDone), .convData(convData),
        .faultBrake(faultBrake), .pwmRunClear(pwmRunClear), .pinRaw(pinRaw), .pinDigital(pinDigital), .irq(irq));
    adc_converter_model u_conv (.clk(clk), .rst(rst), .convStart(convStart), .nextData(nextData),
        .adcTick(adcTick), .convDone(convDone), .convData(convData));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // non-blocking counts so readers after an edge see a stable value
    always @(posedge clk) begin
        if (convStart === 1'b1) begin
            starts <= starts + 1;
            lastTicks <= ticks;
        end
        if (adcTick === 1'b1) ticks <= ticks + 1;
        if (pwmRunClear === 1'b1) clears <= clears + 1;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
        @(posedge clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.paddr <= {idx, 2'b00};
        apbReq.pwrite <= wr;
        apbReq.pwdata <= wd;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (apbRsp.pready !== 1'b1) @(posedge clk);
        rdData = apbRsp.prdata;
        lastErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [8:0] idx, input logic [31:0] expv);
        apb(1'b0, idx, 32'h0);
        chk(what, rdData, expv);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        rdData = 32'h0;
        while (rdData[RUN_DONE] !== 1'b1 && n < 1500) begin
            apb(1'b0, IDX_RUN, 32'h0);
            n++;
        end
    endtask

    task automatic conv(input logic [7:0] ctl, input logic [11:0] data, input logic [7:0] expCtl);
        apb(1'b1, IDX_CTRL2, {24'h0, ctl});
        nextData <= data;
        apb(1'b1, IDX_RUN, 32'h1);
        wait_done();
        rd_chk("result_high", IDX_RESULT_HIGH, {24'h0, data[11:4]});
        rd_chk("result_low", IDX_RESULT_LOW, {28'h0, data[3:0]});
        rd_chk("control compare bit", IDX_CTRL2, {24'h0, expCtl});
        apb(1'b1, IDX_RUN, 32'h0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        apbReq = '0;
        extTrigPin = 1'b0;
        pinRaw = 8'h00;
        nextData = 12'h000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (regIdx[i]) rd_chk("reset value", regIdx[i], 32'h0);
        chk("irq at reset", {31'h0, irq}, 32'h0);
        $display("test reset done");
        apb(1'b1, IDX_COMPARE_HIGH, 32'h80);
        apb(1'b1, IDX_COMPARE_LOW, 32'hF3);
        rd_chk("compare_high", IDX_COMPARE_HIGH, 32'h80);
        rd_chk("compare_low", IDX_COMPARE_LOW, 32'h03);
        apb(1'b1, IDX_RESULT_HIGH, 32'h55);
        rd_chk("result_high write ignored", IDX_RESULT_HIGH, 32'h0);
        rd_chk("unmapped read", 9'h010, 32'h0);
        chk("unmapped error", {31'h0, lastErr}, 32'h1);
        $display("test registers done");
        apb(1'b1, IDX_IRQ_ENABLE, 32'h1);
        // threshold 0x803: equal and one-below cases for both polarities
        for (int i = 0; i < 5; i++) conv(ctlTab[i], datTab[i], expTab[i]);
        $display("test compare done");
        s0 = starts;
        apb(1'b1, IDX_RUN, 32'h1);
        wait_done();
        apb(1'b1, IDX_RUN, 32'h1);
        repeat (10) @(posedge clk);
        chk("start blocked while done", starts - s0, 1);
        chk("irq on done", {31'h0, irq}, 32'h1);
        apb(1'b1, IDX_IRQ_ENABLE, 32'h0);
        @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, IDX_RUN, 32'h0);
        apb(1'b1, IDX_IRQ_ENABLE, 32'h1);
        @(posedge clk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        apb(1'b1, IDX_IRQ_CLEAR, 32'h1);
        @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0);
        chk("status done cleared", {31'h0, rdData[IRQ_DONE]}, 32'h0);
        $display("test done flag and irq done");
        t0 = clears;
        conv(8'hA0, 12'hFFF, 8'hB0);
        chk("brake on", {31'h0, faultBrake}, 32'h1);
        chk("run clear pulses", clears - t0, 1);
        rd_chk("status after brake", IDX_IRQ_STATUS, 32'h7);
        apb(1'b1, IDX_CTRL2, 32'h20);
        repeat (2) @(posedge clk);
        chk("brake off", {31'h0, faultBrake}, 32'h0);
        $display("test brake done");
        apb(1'b1, IDX_DELAY_LOW, 32'h03); // delay set before external triggers are enabled
        apb(1'b1, IDX_CTRL2, 32'h01);
        rd_chk("delay bit 8", IDX_CTRL2, 32'h01);
        t0 = ticks;
        apb(1'b1, IDX_RUN, 32'h1);
        wait_done();
        chk("software start undelayed", {31'h0, (lastTicks - t0) < 2}, 32'h1);
        apb(1'b1, IDX_RUN, 32'h2);
        s0 = starts;
        do @(posedge clk); while (adcTick !== 1'b1);
        extTrigPin <= 1'b1;
        @(posedge clk);
        t0 = ticks;
        // a second edge in mid-delay must be dropped
        repeat (20) @(posedge clk);
        extTrigPin <= 1'b0;
        repeat (5) @(posedge clk);
        extTrigPin <= 1'b1;
        repeat (5) @(posedge clk);
        extTrigPin <= 1'b0;
        wait_done();
        chk("delay ticks", lastTicks - t0, 259);
        chk("one start per trigger", starts - s0, 1);
        apb(1'b1, IDX_RUN, 32'h0);
        apb(1'b1, IDX_DELAY_LOW, 32'h00); // rewritten only while external triggers are off
        apb(1'b1, IDX_CTRL2, 32'h00);
        apb(1'b1, IDX_RUN, 32'h2);
        s0 = starts;
        extTrigPin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("zero delay start", starts - s0, 1);
        extTrigPin <= 1'b0;
        wait_done();
        apb(1'b1, IDX_RUN, 32'h0);
        $display("test delay done");
        pinRaw <= 8'hA5;
        apb(1'b1, IDX_DISCONNECT, 32'h0F);
        rd_chk("disconnect", IDX_DISCONNECT, 32'h0F);
        repeat (4) @(posedge clk);
        chk("pins cut", {24'h0, pinDigital}, 32'hA0);
        apb(1'b1, IDX_DISCONNECT, 32'h00);
        repeat (4) @(posedge clk);
        chk("pins open", {24'h0, pinDigital}, 32'hA5);
        $display("test pins done");
        tally_and_finish();
    end
endmodule
